// *** sfwg_regs.vh ***
// Purpose: constants for the serial flash write guard
// Assumes: 21-bit byte address, 32 sectors of 64KB
// Notes:   included by both design files
`ifndef SFWG_REGS_VH
`define SFWG_REGS_VH
`define SFWG_ADDR_W      21
`define SFWG_TOP_ADDR    21'h1FFFFF
`define SFWG_SECT_MSB    20
`define SFWG_SECT_LSB    16
`define SFWG_SUB32_LSB   15
`define SFWG_SUB4_LSB    12
`define SFWG_PAGE_LSB    8
`define SFWG_NUM_SECT    32
`define SFWG_OTP_W       6
`define SFWG_OTP_BYTES   64
// command codes on cmd_op
`define SFWG_OP_NONE     3'h0
`define SFWG_OP_PROG     3'h1
`define SFWG_OP_ERASE4   3'h2
`define SFWG_OP_ERASE32  3'h3
`define SFWG_OP_ERASE64  3'h4
`define SFWG_OP_BULK     3'h5
`define SFWG_OP_LOCKWR   3'h6
`define SFWG_OP_OTPPROG  3'h7
// refusal reasons on result_code
`define SFWG_RES_OK      3'h0
`define SFWG_RES_PARTIAL 3'h1
`define SFWG_RES_NOWEL   3'h2
`define SFWG_RES_LOCK    3'h3
`define SFWG_RES_BP      3'h4
`define SFWG_RES_FROZEN  3'h5
`define SFWG_RES_BADOP   3'h6
`endif

// *** sfwg_lock_mem.v ***
// Purpose: per-sector write-lock and lock-down bits
// Assumes: one clock, synchronous active-high reset
// Notes:   read data is registered; reset clears both bits of every sector
`timescale 1ns/1ps
`include "sfwg_regs.vh"
module sfwg_lock_mem #(
   parameter NSECT = `SFWG_NUM_SECT,
   parameter AW    = 5
) (
   input  wire          clk,
   input  wire          rst,
   input  wire [AW-1:0] rd_sect,
   output reg           rd_wlock,
   output reg           rd_ldown,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_sect,
   input  wire          wr_wlock,
   input  wire          wr_ldown,
   output reg  [NSECT-1:0] wlock_vec
);
   reg [NSECT-1:0] ldown_reg;
   integer i;

   // storage; reset or power cycle is the only way out of lock-down
   always @(posedge clk) begin
      if (rst) begin
         wlock_vec <= {NSECT{1'b0}};
         ldown_reg <= {NSECT{1'b0}};
         rd_wlock  <= 1'b0;
         rd_ldown  <= 1'b0;
      end else begin
         for (i = 0; i < NSECT; i = i + 1) begin
            if (wr_en && (wr_sect == i[AW-1:0]) && !ldown_reg[i]) begin
               wlock_vec[i] <= wr_wlock;
               ldown_reg[i] <= wr_ldown;
            end
         end
         rd_wlock <= wlock_vec[rd_sect];
         rd_ldown <= ldown_reg[rd_sect];
      end
   end
endmodule

// *** sfwg_guard.v ***
// Purpose: write permission and address decode for a 16-Mbit serial NOR flash
// Assumes: a protocol engine presents one decoded command per cmd_valid pulse
// Notes:   array contents live elsewhere; this block only grants or refuses
`timescale 1ns/1ps
`include "sfwg_regs.vh"
module sfwg_guard #(
   parameter NSECT = `SFWG_NUM_SECT
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        cmd_valid,
   input  wire [2:0]  cmd_op,
   input  wire [20:0] cmd_addr,
   input  wire [15:0] cmd_clk_count,
   input  wire [7:0]  cmd_data,
   input  wire        cmd_lock_wlock,
   input  wire        cmd_lock_ldown,
   input  wire        wel,
   input  wire [2:0]  protect_level_field,
   input  wire        top_bottom,
   input  wire        write_protect_n,
   output reg         grant_valid,
   output reg         grant_ok,
   output reg  [2:0]  result_code,
   output reg  [2:0]  grant_op,
   output reg  [20:0] grant_start,
   output reg  [20:0] grant_end,
   output reg  [7:0]  grant_and_mask,
   output reg  [5:0]  grant_otp_addr,
   output reg  [4:0]  grant_sector,
   output reg  [5:0]  grant_sub32,
   output reg  [8:0]  grant_sub4,
   output reg  [12:0] grant_page,
   output reg         wel_clear,
   output reg         wp_level_sync,
   output reg  [NSECT-1:0] sector_wlock
);
   // sequencer states; the middle state only waits out the registered lock read
   localparam ST_IDLE  = 2'h0;
   localparam ST_LOOK  = 2'h1;
   localparam ST_DEC   = 2'h2;

   // command fields are frozen at the taking edge, so a host that moves them
   // early cannot change a decision already under way
   reg [1:0]  state_reg;
   reg [2:0]  op_reg;
   reg [20:0] addr_reg;
   reg        whole_reg;
   reg        wel_reg;
   reg [7:0]  data_reg;
   reg        lw_reg;
   reg        ld_reg;
   reg        wp_s1_reg;
   reg        wp_s2_reg;
   reg        wp_s3_reg;
   reg        wp_act_reg;

   // only the lock-down bit is read per sector; write-lock comes from the
   // full vector because bulk erase has to see every sector at once
   wire          rd_ldown;
   wire [NSECT-1:0] wlock_vec;
   reg           lock_wr_en;

   // protect-level decode: is sector s inside the protect-bit region
   function bp_hit;
      input [4:0] s;
      input [2:0] lvl;
      input       tb;
      reg   [4:0] e;
      begin
         e = tb ? s : ~s;   // distance from the guarded end
         case (lvl)
            3'h0:    bp_hit = 1'b0;
            3'h1:    bp_hit = (e < 5'h01);
            3'h2:    bp_hit = (e < 5'h02);
            3'h3:    bp_hit = (e < 5'h04);
            3'h4:    bp_hit = (e < 5'h08);
            3'h5:    bp_hit = (e < 5'h10);
            default: bp_hit = 1'b1;
         endcase
      end
   endfunction

   // any protected sector inside an inclusive sector span
   function span_prot;
      input [4:0]       lo;
      input [4:0]       hi;
      input [NSECT-1:0] wl;
      input [2:0]       lvl;
      input             tb;
      integer k;
      begin
         span_prot = 1'b0;
         for (k = 0; k < NSECT; k = k + 1) begin
            if ((k >= lo) && (k <= hi) && (wl[k] || bp_hit(k[4:0], lvl, tb)))
               span_prot = 1'b1;
         end
      end
   endfunction

   sfwg_lock_mem #(
      .NSECT (NSECT),
      .AW    (5)
   ) u_lock (
      .clk       (clk),
      .rst       (rst),
      .rd_sect   (addr_reg[`SFWG_SECT_MSB:`SFWG_SECT_LSB]),
      .rd_wlock  (),
      .rd_ldown  (rd_ldown),
      .wr_en     (lock_wr_en),
      .wr_sect   (addr_reg[`SFWG_SECT_MSB:`SFWG_SECT_LSB]),
      .wr_wlock  (lw_reg),
      .wr_ldown  (ld_reg),
      .wlock_vec (wlock_vec)
   );

   // protect pin sync: three stages, act when stages two and three agree
   // stages reset to the idle pin level so no false protect edge follows reset
   always @(posedge clk) begin
      if (rst) begin
         wp_s1_reg  <= 1'b1;
         wp_s2_reg  <= 1'b1;
         wp_s3_reg  <= 1'b1;
         wp_act_reg <= 1'b0;
      end else begin
         wp_s1_reg <= write_protect_n;
         wp_s2_reg <= wp_s1_reg;
         wp_s3_reg <= wp_s2_reg;
         if (wp_s2_reg == wp_s3_reg)
            wp_act_reg <= ~wp_s3_reg;
      end
   end

   // span of the target, by erase granularity
   // a program spans its whole page even when fewer bytes are sent
   reg [20:0] span_lo;
   reg [20:0] span_hi;
   reg        op_legal;
   always @* begin
      span_lo  = addr_reg;
      span_hi  = addr_reg;
      op_legal = 1'b1;
      case (op_reg)
         `SFWG_OP_PROG: begin   // page-wide window
            span_lo = {addr_reg[20:`SFWG_PAGE_LSB], 8'h00};
            span_hi = {addr_reg[20:`SFWG_PAGE_LSB], 8'hFF};
         end
         `SFWG_OP_ERASE4: begin
            span_lo = {addr_reg[20:`SFWG_SUB4_LSB], 12'h000};
            span_hi = {addr_reg[20:`SFWG_SUB4_LSB], 12'hFFF};
         end
         `SFWG_OP_ERASE32: begin
            span_lo = {addr_reg[20:`SFWG_SUB32_LSB], 15'h0000};
            span_hi = {addr_reg[20:`SFWG_SUB32_LSB], 15'h7FFF};
         end
         `SFWG_OP_ERASE64: begin
            span_lo = {addr_reg[20:`SFWG_SECT_LSB], 16'h0000};
            span_hi = {addr_reg[20:`SFWG_SECT_LSB], 16'hFFFF};
         end
         `SFWG_OP_BULK: begin
            span_lo = 21'h000000;
            span_hi = `SFWG_TOP_ADDR;
         end
         `SFWG_OP_LOCKWR: begin
            span_lo = addr_reg;
         end
         `SFWG_OP_OTPPROG: begin   // never touches array addresses
            span_lo = addr_reg;
         end
         default: op_legal = 1'b0;
      endcase
   end

   // protection verdict for the span; protect-bit region is enforced only
   // while the protect pin is active, lock bits always
   wire [2:0] eff_lvl = wp_act_reg ? protect_level_field : 3'h0;
   wire       is_array = (op_reg != `SFWG_OP_LOCKWR) && (op_reg != `SFWG_OP_OTPPROG);
   // sector numbers at both ends of the span
   wire [4:0] sect_lo  = span_lo[`SFWG_SECT_MSB:`SFWG_SECT_LSB];
   wire [4:0] sect_hi  = span_hi[`SFWG_SECT_MSB:`SFWG_SECT_LSB];
   // write-lock and protect level are judged apart so the refusal code says
   // which one stopped the command
   wire       hit_lock = is_array &&
              span_prot(sect_lo, sect_hi, wlock_vec, 3'h0, top_bottom);
   wire       hit_bp   = is_array &&
              span_prot(sect_lo, sect_hi, {NSECT{1'b0}}, eff_lvl, top_bottom);

   // command sequencer: capture, lock lookup, decide
   reg [2:0] res_next;
   always @* begin
      if (!whole_reg)
         res_next = `SFWG_RES_PARTIAL;
      else if (!op_legal)
         res_next = `SFWG_RES_BADOP;
      else if (!wel_reg)
         res_next = `SFWG_RES_NOWEL;
      else if (op_reg == `SFWG_OP_LOCKWR && rd_ldown)
         res_next = `SFWG_RES_FROZEN;
      else if (hit_lock)
         res_next = `SFWG_RES_LOCK;
      else if (hit_bp)
         res_next = `SFWG_RES_BP;
      else
         res_next = `SFWG_RES_OK;
   end

   always @(posedge clk) begin
      if (rst) begin
         state_reg      <= ST_IDLE;
         op_reg         <= `SFWG_OP_NONE;
         addr_reg       <= 21'h000000;
         whole_reg      <= 1'b0;
         wel_reg        <= 1'b0;
         data_reg       <= 8'hFF;
         lw_reg         <= 1'b0;
         ld_reg         <= 1'b0;
         lock_wr_en     <= 1'b0;
         grant_valid    <= 1'b0;
         grant_ok       <= 1'b0;
         result_code    <= `SFWG_RES_OK;
         grant_op       <= `SFWG_OP_NONE;
         grant_start    <= 21'h000000;
         grant_end      <= 21'h000000;
         grant_and_mask <= 8'hFF;
         grant_otp_addr <= 6'h00;
         grant_sector   <= 5'h00;
         grant_sub32    <= 6'h00;
         grant_sub4     <= 9'h000;
         grant_page     <= 13'h0000;
         wel_clear      <= 1'b0;
      end else begin
         grant_valid <= 1'b0;
         wel_clear   <= 1'b0;
         lock_wr_en  <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (cmd_valid) begin
                  op_reg    <= cmd_op;
                  addr_reg  <= cmd_addr;
                  whole_reg <= (cmd_clk_count[2:0] == 3'h0);   // whole bytes
                  wel_reg   <= wel;
                  data_reg  <= cmd_data;
                  lw_reg    <= cmd_lock_wlock;
                  ld_reg    <= cmd_lock_ldown;
                  state_reg <= ST_LOOK;
               end
            end
            ST_LOOK: begin
               state_reg <= ST_DEC;   // lock read data is registered
            end
            ST_DEC: begin
               grant_valid    <= 1'b1;
               grant_ok       <= (res_next == `SFWG_RES_OK);
               result_code    <= res_next;
               grant_op       <= op_reg;
               grant_start    <= span_lo;
               grant_end      <= span_hi;
               grant_and_mask <= data_reg;   // array ANDs, never sets a bit
               grant_otp_addr <= addr_reg[`SFWG_OTP_W-1:0];
               grant_sector   <= addr_reg[`SFWG_SECT_MSB:`SFWG_SECT_LSB];
               grant_sub32    <= addr_reg[`SFWG_SECT_MSB:`SFWG_SUB32_LSB];
               grant_sub4     <= addr_reg[`SFWG_SECT_MSB:`SFWG_SUB4_LSB];
               grant_page     <= addr_reg[`SFWG_SECT_MSB:`SFWG_PAGE_LSB];
               lock_wr_en     <= (op_reg == `SFWG_OP_LOCKWR) &&
                                 (res_next == `SFWG_RES_OK);
               // latch clears after any whole-byte modifying command, as usual
               wel_clear      <= whole_reg && op_legal && wel_reg;
               state_reg      <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // status copies; they trail the live state by one cycle, so a lock write
   // shows on sector_wlock two edges after its decision pulse
   always @(posedge clk) begin
      if (rst) begin
         wp_level_sync <= 1'b0;
         sector_wlock  <= {NSECT{1'b0}};
      end else begin
         wp_level_sync <= wp_act_reg;
         sector_wlock  <= wlock_vec;
      end
   end
endmodule

// *** sfwg_guard_properties.sv ***
// Purpose: concurrent checks on the guard decision ports
// Assumes: commands are offered no closer than one decision apart
// Notes:   the answer lands three edges after the taking edge
`timescale 1ns/1ps
`include "sfwg_regs.vh"
module sfwg_guard_props #(
   parameter NSECT = 32
) (
   input wire             clk,
   input wire             rst,
   input wire             cmd_valid,
   input wire [2:0]       cmd_op,
   input wire [20:0]      cmd_addr,
   input wire [15:0]      cmd_clk_count,
   input wire [7:0]       cmd_data,
   input wire             wel,
   input wire             grant_valid,
   input wire             grant_ok,
   input wire [2:0]       result_code,
   input wire [2:0]       grant_op,
   input wire [20:0]      grant_start,
   input wire [20:0]      grant_end,
   input wire [7:0]       grant_and_mask,
   input wire [4:0]       grant_sector,
   input wire             wel_clear,
   input wire [NSECT-1:0] sector_wlock
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   answer_time_a: assert property (cmd_valid |-> ##3 grant_valid)
      else $error("decision late");
   single_pulse_a: assert property (grant_valid |=> !grant_valid)
      else $error("decision pulse too long");
   partial_byte_a: assert property ($past(cmd_valid, 3) && $past(cmd_op, 3) != 3'h0 &&
      $past(cmd_clk_count[2:0], 3) != 3'h0 |-> result_code == `SFWG_RES_PARTIAL && !grant_ok)
      else $error("partial byte not discarded");
   no_enable_a: assert property ($past(cmd_valid, 3) && $past(cmd_op, 3) != 3'h0 &&
      $past(cmd_clk_count[2:0], 3) == 3'h0 && !$past(wel, 3) |-> result_code == `SFWG_RES_NOWEL)
      else $error("command without latch not refused");
   ok_code_a: assert property (grant_valid |-> grant_ok == (result_code == `SFWG_RES_OK))
      else $error("grant and code disagree");
   wel_used_a: assert property (wel_clear |-> grant_valid && $past(wel, 3))
      else $error("latch cleared without cause");
   lock_refuse_a: assert property (grant_ok && grant_op inside {[3'h1:3'h4]} |->
      !sector_wlock[grant_sector]) else $error("locked sector granted");
   prog_span_a: assert property (grant_valid && grant_ok &&
      grant_op == `SFWG_OP_PROG |-> grant_and_mask == $past(cmd_data, 3) &&
      grant_start[7:0] == 8'h00 && grant_end == {grant_start[20:8], 8'hFF})
      else $error("program span wrong");
   sector_dec_a: assert property (grant_valid && $past(cmd_op, 3) inside {[3'h1:3'h4]} |->
      grant_sector == $past(cmd_addr[20:16], 3)) else $error("sector decode wrong");
   // main scenarios reached
   cover property (grant_ok && grant_op == `SFWG_OP_PROG);
   cover property (grant_valid && result_code == `SFWG_RES_FROZEN);
   cover property (grant_valid && result_code == `SFWG_RES_BP);
endmodule
bind sfwg_guard sfwg_guard_props #(.NSECT(NSECT)) u_props (.clk(clk), .rst(rst),
   .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_clk_count(cmd_clk_count),
   .cmd_data(cmd_data), .wel(wel), .grant_valid(grant_valid), .grant_ok(grant_ok),
   .result_code(result_code), .grant_op(grant_op), .grant_start(grant_start),
   .grant_end(grant_end), .grant_and_mask(grant_and_mask), .grant_sector(grant_sector),
   .wel_clear(wel_clear), .sector_wlock(sector_wlock));

// *** sfwg_host_model.sv ***
// Purpose: host side that raises the command strobe and keeps the enable latch
// Assumes: the bench places command fields one edge before the strobe
// Notes:   latch is cleared by reset or by the guard, so a partial-byte or illegal command leaves it set
`timescale 1ns/1ps
module sfwg_host_model (
   input  wire clk,
   input  wire rst,
   input  wire go,
   input  wire wren,
   input  wire wel_clear,
   output reg  cmd_valid,
   output reg  wel
);
   // write enable goes ahead of the modifying command, one edge apart
   always @(posedge clk) begin
      cmd_valid <= go & ~rst;
      if (rst)
         wel <= 1'b0;
      else if (wren)
         wel <= 1'b1;
      else if (wel_clear)
         wel <= 1'b0;
   end
endmodule

// *** serial_flash_write_guard_bench.sv ***
// Purpose: self-checking bench for the write guard
// Assumes: one command in flight at a time
// Notes:   table rows first, then level sweep, locks and a mid-run reset
`timescale 1ns/1ps
`include "sfwg_regs.vh"
`define SFWG_CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
   $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module serial_flash_write_guard_bench;
   typedef struct packed {logic [2:0] o; logic [20:0] a; logic [15:0] c; logic w; logic [2:0] e;}
      sfwg_row_t;
   logic        clk, rst, go, wren, cmd_lock_wlock, cmd_lock_ldown, top_bottom, write_protect_n;
   logic [2:0]  cmd_op, protect_level_field;
   logic [20:0] cmd_addr;
   logic [15:0] cmd_clk_count;
   logic [7:0]  cmd_data;
   wire         cmd_valid, wel, grant_valid, grant_ok, wel_clear, wp_level_sync;
   wire [2:0]   result_code, grant_op;
   wire [20:0]  grant_start, grant_end;
   wire [7:0]   grant_and_mask;
   wire [5:0]   grant_otp_addr, grant_sub32;
   wire [4:0]   grant_sector;
   wire [8:0]   grant_sub4;
   wire [12:0]  grant_page;
   wire [31:0]  sector_wlock;
   int          fails, num_checks, t, l, n;
   // nowel row follows an erase that used up the latch
   sfwg_row_t rows [9] = '{'{1, 21'h012345, 40, 1, 0}, '{1, 21'h012345, 41, 1, 1},
      '{2, 21'h0ABCDE, 32, 1, 0}, '{1, 21'h012345, 40, 0, 2}, '{3, 21'h1F8123, 32, 1, 0},
      '{4, 21'h1E4567, 32, 1, 0}, '{5, 21'h000000, 8, 1, 0}, '{7, 21'h00002A, 48, 1, 0},
      '{0, 21'h000000, 8, 1, 6}};
   sfwg_guard u_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_clk_count(cmd_clk_count), .cmd_data(cmd_data),
      .cmd_lock_wlock(cmd_lock_wlock), .cmd_lock_ldown(cmd_lock_ldown), .wel(wel),
      .protect_level_field(protect_level_field), .top_bottom(top_bottom),
      .write_protect_n(write_protect_n), .grant_valid(grant_valid), .grant_ok(grant_ok),
      .result_code(result_code), .grant_op(grant_op), .grant_start(grant_start),
      .grant_end(grant_end), .grant_and_mask(grant_and_mask), .grant_otp_addr(grant_otp_addr),
      .grant_sector(grant_sector), .grant_sub32(grant_sub32), .grant_sub4(grant_sub4),
      .grant_page(grant_page), .wel_clear(wel_clear), .wp_level_sync(wp_level_sync),
      .sector_wlock(sector_wlock));
   sfwg_host_model u_host (.clk(clk), .rst(rst), .go(go), .wren(wren), .wel_clear(wel_clear),
      .cmd_valid(cmd_valid), .wel(wel));
   // 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task final_report;
      begin
         $display("checks %0d mismatches %0d", num_checks, fails);
         if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // enable, strobe, then wait a bounded span for the decision pulse
   task run(input [2:0] o, input [20:0] a, input [15:0] c, input w, input [2:0] e);
      logic        seen, wc;
      logic [20:0] m;
      begin
         @(posedge clk) wren <= w;
         @(posedge clk) wren <= 1'b0;
         go <= 1'b1; cmd_op <= o; cmd_addr <= a; cmd_clk_count <= c; cmd_data <= a[7:0] ^ 8'hC3;
         @(posedge clk) go <= 1'b0;
         seen = 1'b0;
         for (int i = 0; i < 8 && !seen; i++) begin
            @(posedge clk) seen = (grant_valid === 1'b1);
            wc = wel_clear;
         end
         m = o == 1 ? 21'hFF : o == 2 ? 21'hFFF : o == 3 ? 21'h7FFF : o == 4 ? 21'hFFFF : 21'h1FFFFF;
         `SFWG_CHK("grant_valid", 1'b1, seen)
         `SFWG_CHK("result_code", e, result_code)
         `SFWG_CHK("grant_ok", e == 0, grant_ok)
         `SFWG_CHK("grant_op", o, grant_op)
         if (e < 2) `SFWG_CHK("wel_clear", e == 0, wc)
         if (e == 0 && o inside {[1:5]}) `SFWG_CHK("span", {a & ~m, a | m}, {grant_start, grant_end})
         if (e == 0 && o == 1) `SFWG_CHK("and_mask", a[7:0] ^ 8'hC3, grant_and_mask)
         if (e == 0 && o == 7) `SFWG_CHK("otp_addr", a[5:0], grant_otp_addr)
         if (e == 0 && o inside {[1:4]}) `SFWG_CHK("decode", {a[20:16], a[20:15], a[20:12], a[20:8]},
            {grant_sector, grant_sub32, grant_sub4, grant_page})
      end
   endtask
   // protect pin passes a synchroniser, so allow it to settle
   task setp(input [2:0] lv, input tbv, input wpv);
      begin
         protect_level_field <= lv; top_bottom <= tbv; write_protect_n <= wpv;
         repeat (8) @(posedge clk);
         `SFWG_CHK("wp_level_sync", ~wpv, wp_level_sync)
      end
   endtask
   initial begin
      #(25 * 5000);
      fails++;
      final_report;
   end
   initial begin
      rst = 1'b1; go = 1'b0; wren = 1'b0; cmd_op = 3'h0; cmd_addr = 21'h0; cmd_clk_count = 16'h0;
      cmd_data = 8'h0; cmd_lock_wlock = 1'b0; cmd_lock_ldown = 1'b0; protect_level_field = 3'h0;
      top_bottom = 1'b0; write_protect_n = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[k]) run(rows[k].o, rows[k].a, rows[k].c, rows[k].w, rows[k].e);
      // edge sector of each protected region and its unprotected neighbour
      for (t = 0; t < 2; t++)
         for (l = 0; l < 8; l++) begin
            n = l == 0 ? 0 : l > 5 ? 32 : 1 << (l - 1);
            setp(l, t, 1'b0);
            if (n > 0) run(1, {5'(t ? n - 1 : 32 - n), 16'h1234}, 40, 1, 3'h4);
            if (n < 32) run(1, {5'(t ? n : 31 - n), 16'h1234}, 40, 1, 3'h0);
         end
      setp(6, 0, 1'b1);
      run(1, 21'h1F0000, 40, 1, 3'h0);
      setp(0, 0, 1'b1);
      cmd_lock_wlock <= 1'b1;
      run(6, 21'h050000, 32, 1, 3'h0);
      repeat (2) @(posedge clk);
      `SFWG_CHK("sector_wlock", 32'h0000_0020, sector_wlock)
      run(1, 21'h05ABCD, 40, 1, 3'h3);
      run(2, 21'h05F000, 32, 1, 3'h3);
      cmd_lock_wlock <= 1'b0;
      cmd_lock_ldown <= 1'b1;
      run(6, 21'h050000, 32, 1, 3'h0);
      cmd_lock_wlock <= 1'b1;
      run(6, 21'h050000, 32, 1, 3'h5);
      repeat (2) @(posedge clk);
      `SFWG_CHK("frozen_wlock", 32'h0, sector_wlock)
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `SFWG_CHK("reset_state", {2'b00, 8'hFF, 32'h0},
         {grant_valid, grant_ok, grant_and_mask, sector_wlock})
      run(6, 21'h050000, 32, 1, 3'h0);
      final_report;
   end
endmodule
